// ==== adcctl_top.sv ====
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "adcctl_regs.svh"

// What this block does
// - Pin select 00 leaves all three candidate pins digital.
// - Codes 01, 10, 11 add input 2, then input 0, then input 1.
// - Selected analog pins are forced to analog mode.
// - A forced pin stays connected to both comparator and converter.
// - Channel codes pick input 0, 1, 2 or the fixed reference.
// - Writing one to the go flag, with on also written one, starts a conversion.
// - Hardware clears the go flag when conversion finishes.
// - Clearing the go flag mid-conversion aborts it.
// - Converter runs only while converter_on is one.
// - The go flag cannot be set while converter_on is zero.
// - Any reset returns pin select to 11.
// - Control resets to FC hex; all bits are read-write, but go is stored only when on is written one too.
// - Result is an eight-bit read-only register, MSB at bit 7.
// - Writing zero to control makes pins digital and powers off.
// - Thirteen bit periods per conversion at the selected divisor.
// - Clock and channel changes apply at the next start.
// - Sleep clears go and on, forces clock and channel to 11.
// - Result cleared, leading one shifted right, done after 9 shifts.

module adcctl_top
    import adcctl_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        osc_tick,
    input  wire logic        sleep_enter,
    input  wire logic        cmp_bit,
    output logic      [2:0]  analog_pin_en,
    output logic      [2:0]  cmp_pin_keep,
    output logic      [1:0]  sample_chan,
    output logic             sample_en,
    output logic      [7:0]  dac_code,
    output logic             converter_pwr
);

    ////////////////////////////////////////////////////////////////////////
    // Register state.

    logic [7:0]    ctrl_ff;
    logic [7:0]    result_ff;
    logic [7:0]    ring_ff;
    logic [1:0]    run_clk_ff;
    logic [1:0]    run_chan_ff;
    logic [3:0]    period_ff;
    adcctl_state_t state_ff;
    logic          busy;
    logic          wr_ctrl;
    logic          wr_sleep;
    logic          rd_en;
    logic          tick;
    logic          done;
    logic          start;
    logic [7:0]    wdat;
    logic [31:0]   nxt_prdata;
    logic          nxt_pslverr;
    logic          addr_ok;

    adcctl_tick_if tk_if ();

    adcctl_tick u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .osc_tick(osc_tick),
        .tk      (tk_if.gen)
    );

    assign tk_if.run     = (state_ff != ADCCTL_IDLE);
    assign tk_if.clk_sel = run_clk_ff;
    assign tick          = tk_if.tick;
    assign busy          = (state_ff != ADCCTL_IDLE);
    assign wdat          = pwdata[7:0];

    ////////////////////////////////////////////////////////////////////////
    // APB decode.

    assign wr_ctrl  = psel && penable && pwrite && pready
                      && (paddr == `ADCCTL_CTRL_OFFSET);
    assign wr_sleep = psel && penable && pwrite && pready
                      && (paddr == `ADCCTL_SLEEP_OFFSET);
    assign rd_en    = psel && !penable && !pwrite;

    always_comb begin
        addr_ok = 1'b1;
        nxt_prdata = 32'h0000_0000;
        if (paddr == `ADCCTL_CTRL_OFFSET) begin
            nxt_prdata = {24'h00_0000, ctrl_ff};
        end else if (paddr == `ADCCTL_RESULT_OFFSET) begin
            nxt_prdata = {24'h00_0000, result_ff};
        end else if (paddr == `ADCCTL_STATUS_OFFSET) begin
            nxt_prdata = {30'h0000_0000, state_ff};
        end else if (paddr == `ADCCTL_SLEEP_OFFSET) begin
            nxt_prdata = 32'h0000_0000;
        end else begin
            addr_ok = 1'b0;
        end
        nxt_pslverr = psel && !penable && !addr_ok;
    end

    // No access gets a wait state; pready rises in the first access-phase cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= nxt_pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= nxt_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register.

    assign start = wr_ctrl && wdat[`ADCCTL_GO_BIT] && wdat[`ADCCTL_ON_BIT]
                   && !ctrl_ff[`ADCCTL_GO_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `ADCCTL_CTRL_RESET;
        end else if (sleep_enter || wr_sleep) begin
            ctrl_ff[5:0] <= 6'h3C;
        end else if (wr_ctrl) begin
            ctrl_ff <= wdat;
            ctrl_ff[`ADCCTL_GO_BIT] <= wdat[`ADCCTL_GO_BIT]
                                       && wdat[`ADCCTL_ON_BIT];
        end else if (done) begin
            ctrl_ff[`ADCCTL_GO_BIT] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer.

    // Settings are latched only when a conversion starts.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_clk_ff  <= `ADCCTL_SELECT_DEFAULT;
            run_chan_ff <= `ADCCTL_SELECT_DEFAULT;
        end else if (start && !busy) begin
            run_clk_ff  <= wdat[`ADCCTL_CLKS_LSB +: 2];
            run_chan_ff <= wdat[`ADCCTL_CHS_LSB +: 2];
        end
    end

    assign done = (state_ff == ADCCTL_CONVERT) && tick && ring_ff[0]
                  && ctrl_ff[`ADCCTL_GO_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff  <= ADCCTL_IDLE;
            period_ff <= 4'h0;
        end else begin
            case (state_ff)
                ADCCTL_IDLE: begin
                    period_ff <= 4'h0;
                    if (start) begin
                        state_ff <= ADCCTL_SAMPLE;
                    end
                end
                ADCCTL_SAMPLE: begin
                    if (!ctrl_ff[`ADCCTL_GO_BIT]) begin
                        state_ff <= ADCCTL_IDLE;
                    end else if (tick) begin
                        period_ff <= period_ff + 4'h1;
                        if (period_ff == 4'(`ADCCTL_SAMPLE_PERIODS - 1)) begin
                            state_ff <= ADCCTL_CONVERT;
                        end
                    end
                end
                ADCCTL_CONVERT: begin
                    if (!ctrl_ff[`ADCCTL_GO_BIT] || done) begin
                        state_ff <= ADCCTL_IDLE;
                    end
                end
                default: begin
                    state_ff <= ADCCTL_IDLE;
                end
            endcase
        end
    end

    // Leading one marks the bit under trial; the result holds kept bits.
    // The first convert period shifts the leading one in, nine in all.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_ff   <= 8'h00;
            result_ff <= 8'h00;
        end else if (state_ff == ADCCTL_SAMPLE && tick && ctrl_ff[1]
                     && period_ff == 4'(`ADCCTL_SAMPLE_PERIODS - 1)) begin
            ring_ff   <= 8'h00;
            result_ff <= 8'h00;
        end else if (state_ff == ADCCTL_CONVERT && tick
                     && ctrl_ff[`ADCCTL_GO_BIT] && ring_ff == 8'h00) begin
            ring_ff   <= 8'h80;
            result_ff <= 8'h80;
        end else if (state_ff == ADCCTL_CONVERT && tick
                     && ctrl_ff[`ADCCTL_GO_BIT]) begin
            ring_ff   <= ring_ff >> 1;
            result_ff <= (result_ff & ~(ring_ff & {8{~cmp_bit}}))
                         | (ring_ff >> 1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin and analog outputs.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_pin_en <= 3'h7;
            cmp_pin_keep  <= 3'h7;
        end else begin
            case (ctrl_ff[`ADCCTL_ANS_LSB +: 2])
                2'h0:    analog_pin_en <= 3'h0;
                2'h1:    analog_pin_en <= 3'h4;
                2'h2:    analog_pin_en <= 3'h5;
                default: analog_pin_en <= 3'h7;
            endcase
            cmp_pin_keep <= 3'h7;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_chan   <= `ADCCTL_SELECT_DEFAULT;
            sample_en     <= 1'b0;
            dac_code      <= 8'h00;
            converter_pwr <= 1'b0;
        end else begin
            sample_chan   <= run_chan_ff;
            sample_en     <= (state_ff == ADCCTL_SAMPLE);
            dac_code      <= result_ff;
            converter_pwr <= ctrl_ff[`ADCCTL_ON_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    go_needs_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_ff[1] |-> ctrl_ff[0]) else $error("go set while off");
    reset_ans_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> ctrl_ff[7:6] == 2'h3)
        else $error("pin select not 11");
    sleep_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_enter && !wr_ctrl) |=> ctrl_ff[5:0] == 6'h3C)
        else $error("sleep did not force fields");
    sleep_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_enter |=> $stable(ctrl_ff[7:6]))
        else $error("sleep changed pin select");
    done_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && !wr_ctrl && !sleep_enter) |=> !ctrl_ff[1] && !busy)
        else $error("go not cleared at done");
    abort_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (busy && !ctrl_ff[1]) |=> !busy)
        else $error("abort ignored");
    start_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        start && !busy |=> state_ff == ADCCTL_SAMPLE)
        else $error("start ignored");
    ans_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_ff[7:6] == 2'h0 |=> analog_pin_en == 3'h0)
        else $error("pins left analog");
    chan_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        busy && $past(busy) |-> $stable(run_chan_ff))
        else $error("channel changed mid-run");
    pwr_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> converter_pwr == $past(ctrl_ff[0]))
        else $error("power not following on bit");

    conv_done_c: cover property (@(posedge pclk) disable iff (!presetn)
        done);
    conv_abort_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_ff == ADCCTL_CONVERT && !ctrl_ff[1]);
    sleep_busy_c: cover property (@(posedge pclk) disable iff (!presetn)
        sleep_enter && busy);
    conv_osc_c: cover property (@(posedge pclk) disable iff (!presetn)
        done && run_clk_ff == 2'h3);

    ring_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == ADCCTL_CONVERT && tick && ctrl_ff[1] && ring_ff == 8'h00)
        |=> ring_ff == 8'h80) else $error("leading one not loaded");
    pins_two_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_ff[7:6] == 2'h2 |=> analog_pin_en == 3'h5)
        else $error("pins wrong for code 10");

endmodule : adcctl_top

// ==== adcctl_regs.svh ====
`ifndef ADCCTL_REGS_SVH
`define ADCCTL_REGS_SVH

`define ADCCTL_CTRL_OFFSET     12'h000
`define ADCCTL_RESULT_OFFSET   12'h004
`define ADCCTL_SLEEP_OFFSET    12'h008
`define ADCCTL_STATUS_OFFSET   12'h00C

`define ADCCTL_ON_BIT          0
`define ADCCTL_GO_BIT          1
`define ADCCTL_CHS_LSB         2
`define ADCCTL_CLKS_LSB        4
`define ADCCTL_ANS_LSB         6

`define ADCCTL_CTRL_RESET      8'hFC
`define ADCCTL_SELECT_DEFAULT  2'h3

`define ADCCTL_BIT_PERIODS     13
`define ADCCTL_SAMPLE_PERIODS  4
`define ADCCTL_DIV_CODE0       16
`define ADCCTL_DIV_CODE1       8
`define ADCCTL_DIV_CODE2       4
`define ADCCTL_DIV_OSC         4

`endif

// ==== adcctl_pkg.sv ====
package adcctl_pkg;

    typedef enum logic [1:0] {
        ADCCTL_CH_IN0,
        ADCCTL_CH_IN1,
        ADCCTL_CH_IN2,
        ADCCTL_CH_VREF
    } adcctl_chan_t;

    typedef enum logic [1:0] {
        ADCCTL_IDLE,
        ADCCTL_SAMPLE,
        ADCCTL_CONVERT
    } adcctl_state_t;

endpackage : adcctl_pkg

// ==== adcctl_tick_if.sv ====
`timescale 1ns/1ps

interface adcctl_tick_if;
    logic       run;
    logic [1:0] clk_sel;
    logic       tick;

    modport ctrl (
        output run,
        output clk_sel,
        input  tick
    );

    modport gen (
        input  run,
        input  clk_sel,
        output tick
    );
endinterface : adcctl_tick_if

// ==== adcctl_tick.sv ====
`timescale 1ns/1ps
`include "adcctl_regs.svh"

module adcctl_tick
    import adcctl_pkg::*;
(
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  osc_tick,
    adcctl_tick_if.gen tk
);

    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [3:0] last;
    logic       step;

    always_comb begin
        last = 4'(`ADCCTL_DIV_CODE2 - 1);
        step = 1'b1;
        if (tk.clk_sel == 2'h0) begin
            last = 4'(`ADCCTL_DIV_CODE0 - 1);
        end else if (tk.clk_sel == 2'h1) begin
            last = 4'(`ADCCTL_DIV_CODE1 - 1);
        end else if (tk.clk_sel == 2'h3) begin
            last = 4'(`ADCCTL_DIV_OSC - 1);
            step = osc_tick;
        end
        nxt_cnt = cnt_ff;
        if (!tk.run) begin
            nxt_cnt = 4'h0;
        end else if (step) begin
            nxt_cnt = (cnt_ff == last) ? 4'h0 : cnt_ff + 4'h1;
        end
    end

    // Counts one bit period in core clocks or oscillator ticks.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // The tick is combinational, so with a core-clock divisor the first bit period is a full one.
    assign tk.tick = tk.run && step && (cnt_ff == last);

endmodule : adcctl_tick

// ==== tb_adcctl_top.sv ====
`timescale 1ns/1ps
`include "adcctl_regs.svh"

module tb_adcctl_top
    import adcctl_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        osc_tick;
    logic        sleep_enter;
    logic        cmp_bit;
    logic [2:0]  analog_pin_en;
    logic [2:0]  cmp_pin_keep;
    logic [1:0]  sample_chan;
    logic        sample_en;
    logic [7:0]  dac_code;
    logic        converter_pwr;
    logic [31:0] rdat;
    logic        rerr;
    logic [7:0]  v;
    logic [1:0]  oc;
    int          cyc;
    int          run_w;
    int          sw;
    int          mismatches;
    int          n_tests;

    adcctl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_tick(osc_tick),
        .sleep_enter(sleep_enter), .cmp_bit(cmp_bit),
        .analog_pin_en(analog_pin_en), .cmp_pin_keep(cmp_pin_keep),
        .sample_chan(sample_chan), .sample_en(sample_en),
        .dac_code(dac_code), .converter_pwr(converter_pwr));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        oc <= (oc == 2'h2) ? 2'h0 : oc + 2'h1;
        osc_tick <= (oc == 2'h2);
        if (sample_en === 1'b1) begin
            run_w <= run_w + 1;
        end else begin
            if (run_w != 0) sw <= run_w;
            run_w <= 0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask : chk

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            k++;
            if (k > 20) begin
                chk("pready", 32'h1, 32'h0);
                complete_run();
            end
            @(posedge pclk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wait_done();
        int k;
        for (k = 0; k < 300; k++) begin
            apb(1'b0, `ADCCTL_CTRL_OFFSET, 32'h0);
            if (rdat[`ADCCTL_GO_BIT] === 1'b0) break;
        end
        if (k == 300) begin
            chk("go flag", 32'h0, 32'h1);
            complete_run();
        end
    endtask : wait_done

    function automatic int per(input logic [1:0] cs);
        case (cs)
            2'h0: per = `ADCCTL_DIV_CODE0;
            2'h1: per = `ADCCTL_DIV_CODE1;
            2'h2: per = `ADCCTL_DIV_CODE2;
            default: per = `ADCCTL_DIV_OSC * 3;
        endcase
    endfunction : per

    function automatic logic [2:0] pins(input logic [1:0] a);
        case (a)
            2'h0: pins = 3'h0;
            2'h1: pins = 3'h4;
            2'h2: pins = 3'h5;
            default: pins = 3'h7;
        endcase
    endfunction : pins

    task conv(input logic [1:0] cs, input logic [1:0] ch, input logic c);
        int t0;
        int p;
        logic ok;
        p = per(cs);
        cmp_bit <= c;
        apb(1'b1, `ADCCTL_CTRL_OFFSET, {24'h0, 2'h3, cs, ch, 2'h3});
        t0 = cyc;
        apb(1'b1, `ADCCTL_CTRL_OFFSET, {24'h0, 2'h3, ~cs, ~ch, 2'h3});
        chk("sample_chan", {30'h0, ch}, {30'h0, sample_chan});
        chk("converter_pwr", 32'h1, {31'h0, converter_pwr});
        wait_done();
        ok = (cyc - t0 >= 13 * p) && (cyc - t0 <= 14 * p + 8);
        chk("conv time", 32'h1, {31'h0, ok});
        if (cs == 2'h3) begin
            ok = (sw >= 4 * p - 2) && (sw <= 4 * p);
            chk("osc sample width", 32'h1, {31'h0, ok});
        end else begin
            chk("sample width", 4 * p, sw);
        end
        apb(1'b0, `ADCCTL_RESULT_OFFSET, 32'h0);
        v = {8{c}};
        chk("result", {24'h0, v}, rdat);
        chk("dac_code", {24'h0, v}, {24'h0, dac_code});
        $display("conversion clock %0d channel %0d done", cs, ch);
    endtask : conv

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {osc_tick, sleep_enter, cmp_bit, oc} = '0;
        {cyc, run_w, sw, mismatches, n_tests} = '0;
        presetn = 1'b0;
        void'($urandom(22));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ADCCTL_CTRL_OFFSET, 32'h0);
        chk("ctrl reset", {24'h0, `ADCCTL_CTRL_RESET}, rdat);
        chk("pins reset", 32'h7, {29'h0, analog_pin_en});
        chk("cmp keep", 32'h7, {29'h0, cmp_pin_keep});
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom());
            v[7:6] = 2'(i);
            v[0] = 1'b0;
            apb(1'b1, `ADCCTL_CTRL_OFFSET, {24'h0, v});
            apb(1'b0, `ADCCTL_CTRL_OFFSET, 32'h0);
            chk("ctrl rw", {24'h0, v[7:2], 2'h0}, rdat);
            chk("pins", {29'h0, pins(v[7:6])},
                {29'h0, analog_pin_en});
            chk("pwr off", 32'h0, {31'h0, converter_pwr});
        end
        $display("pin select test done");
        for (int i = 0; i < 4; i++) begin
            conv(2'(i), 2'(3 - i), 1'($urandom()));
        end
        apb(1'b1, `ADCCTL_RESULT_OFFSET, 32'h5A);
        apb(1'b0, `ADCCTL_RESULT_OFFSET, 32'h0);
        chk("result ro", {24'h0, v}, rdat);
        apb(1'b1, `ADCCTL_CTRL_OFFSET, 32'hC3);
        repeat (80) @(posedge pclk);
        apb(1'b1, `ADCCTL_CTRL_OFFSET, 32'hC1);
        apb(1'b0, `ADCCTL_STATUS_OFFSET, 32'h0);
        chk("abort state", {30'h0, ADCCTL_IDLE}, rdat);
        $display("abort test done");
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `ADCCTL_CTRL_OFFSET, 32'h43);
            repeat (10) @(posedge pclk);
            if (k == 0) begin
                sleep_enter <= 1'b1;
                @(posedge pclk);
                sleep_enter <= 1'b0;
            end else begin
                apb(1'b1, `ADCCTL_SLEEP_OFFSET, 32'h1);
            end
            repeat (2) @(posedge pclk);
            apb(1'b0, `ADCCTL_CTRL_OFFSET, 32'h0);
            chk("sleep ctrl", 32'h7C, rdat);
            chk("sleep pins", 32'h4, {29'h0, analog_pin_en});
        end
        $display("sleep test done");
        apb(1'b1, `ADCCTL_CTRL_OFFSET, 32'h0);
        repeat (2) @(posedge pclk);
        chk("clear pins", 32'h0, {29'h0, analog_pin_en});
        chk("clear pwr", 32'h0, {31'h0, converter_pwr});
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ADCCTL_CTRL_OFFSET, 32'h0);
        chk("ctrl rereset", {24'h0, `ADCCTL_CTRL_RESET}, rdat);
        $display("clear and reset test done");
        complete_run();
    end
endmodule : tb_adcctl_top
